// *** design/sfpi_top.sv ***
// Pin front end of a serial flash: link shifters on the serial clock, status on the core clock.
// Assumes the core answers each received byte with a reply byte well within one byte time.
`timescale 1ns/100ps
// How it works
// - Released select deselects the part; input data is ignored while deselected.
// - An operation starts on select falling and ends on select rising.
// - Standby is withheld while a program or erase cycle still runs.
// - Command, address and data bits are captured on rising serial clock edges.
// - Output data changes on falling serial clock edges.
// - Dual read turns the input line into a second output, two bits per edge.
// - Dual program turns the output line into an input, two bits per edge.
// - The output line floats whenever the part is deselected.
// - Low write protect is reported to the core as the hardware lock status.
// - Asserted hold ignores clock and input and floats the output.
// - Hold only pauses; the command resumes when hold is released.
// - Hold leaves a running program or erase cycle untouched.
module sfpi_top #(
  parameter logic [7:0] DUAL_READ_OP = sfpi_pkg::DUAL_READ_OP_DEF,
  parameter logic [7:0] DUAL_PROG_OP = sfpi_pkg::DUAL_PROG_OP_DEF
) (
  // Core clock and reset.
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Serial link pins.
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic dual_data_line_a_i,
  output logic dual_data_line_a_o,
  output logic dual_data_line_a_oe_n_o,
  input wire logic dual_data_line_b_i,
  output logic dual_data_line_b_o,
  output logic dual_data_line_b_oe_n_o,
  // Core side request and reply.
  input wire logic busy_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  // Core side status.
  output logic frame_start_o,
  output logic frame_end_o,
  output logic selected_o,
  output logic hold_o,
  output logic hw_lock_o,
  output logic standby_o,
  output logic dual_read_o,
  output logic dual_prog_o
);

  typedef struct packed {
    logic [1:0] cs_sync;
    logic cs_last;
    logic [1:0] hold_sync;
    logic [1:0] wp_sync;
    logic [1:0] tog_sync;
    logic tog_last;
    logic [1:0] din_sync;
    logic [1:0] dout_sync;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic frame_start;
    logic frame_end;
    logic standby;
    logic [7:0] tx_hold;
  } sfpi_core_s;

  sfpi_core_s q;
  sfpi_core_s d;

  logic rx_fresh;
  logic rx_byte_any;
  logic rx_boundary;
  logic rx_dual_in;
  logic rx_dual_out;
  logic [7:0] rx_data;
  logic rx_done_tog;
  logic tx_drive;
  logic line_drive;

  // Detects a change between a synchronised level and its previous value.
  function automatic logic sfpi_change(input logic now, input logic last);
    return now ^ last;
  endfunction

  sfpi_rx_shift #(
    .DUAL_READ_OP(DUAL_READ_OP),
    .DUAL_PROG_OP(DUAL_PROG_OP)
  ) u_rx (
    .sck_i(sck_i),
    .nrst_i(nrst_i),
    .cs_n_i(cs_n_i),
    .hold_n_i(hold_n_i),
    .line_a_i(dual_data_line_a_i),
    .line_b_i(dual_data_line_b_i),
    .fresh_o(rx_fresh),
    .byte_any_o(rx_byte_any),
    .boundary_o(rx_boundary),
    .dual_in_o(rx_dual_in),
    .dual_out_o(rx_dual_out),
    .data_o(rx_data),
    .done_tog_o(rx_done_tog)
  );

  sfpi_tx_shift u_tx (
    .sck_i(sck_i),
    .nrst_i(nrst_i),
    .cs_n_i(cs_n_i),
    .hold_n_i(hold_n_i),
    .boundary_i(rx_boundary),
    .byte_any_i(rx_byte_any),
    .dual_out_i(rx_dual_out),
    .tx_byte_i(q.tx_hold),
    .line_a_o(dual_data_line_a_o),
    .line_b_o(dual_data_line_b_o),
    .drive_o(tx_drive)
  );

  // The enables follow the select and hold pins without a clock, so the lines let go at once
  // even when the host stops the serial clock.
  assign line_drive = !cs_n_i && hold_n_i && tx_drive && rx_byte_any && !rx_fresh;
  assign dual_data_line_a_oe_n_o = !(line_drive && !rx_dual_in);
  assign dual_data_line_b_oe_n_o = !(line_drive && rx_dual_out);

  always_comb begin
    d = q;
    d.cs_sync = {q.cs_sync[0], cs_n_i};
    d.cs_last = q.cs_sync[1];
    d.hold_sync = {q.hold_sync[0], hold_n_i};
    d.wp_sync = {q.wp_sync[0], wp_n_i};
    d.tog_sync = {q.tog_sync[0], rx_done_tog};
    d.tog_last = q.tog_sync[1];
    d.din_sync = {q.din_sync[0], rx_dual_in};
    d.dout_sync = {q.dout_sync[0], rx_dual_out};
    d.frame_start = sfpi_change(q.cs_sync[1], q.cs_last) && !q.cs_sync[1];
    d.frame_end = sfpi_change(q.cs_sync[1], q.cs_last) && q.cs_sync[1];
    // The received byte stays put for a whole byte time after its toggle, which covers the
    // synchroniser delay with room to spare.
    d.rx_valid = sfpi_change(q.tog_sync[1], q.tog_last);
    if (d.rx_valid) begin
      d.rx_byte = rx_data;
    end
    if (tx_valid_i) begin
      d.tx_hold = tx_byte_i;
    end
    // Standby ignores hold entirely; hold never touches the busy cycle.
    d.standby = q.cs_sync[1] && !busy_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q.cs_sync <= sfpi_pkg::PIN_SYNC_RST;
      q.cs_last <= 1'b1;
      q.hold_sync <= sfpi_pkg::PIN_SYNC_RST;
      q.wp_sync <= sfpi_pkg::PIN_SYNC_RST;
      q.tog_sync <= sfpi_pkg::LINK_SYNC_RST;
      q.tog_last <= 1'b0;
      q.din_sync <= sfpi_pkg::LINK_SYNC_RST;
      q.dout_sync <= sfpi_pkg::LINK_SYNC_RST;
      q.rx_byte <= sfpi_pkg::BYTE_RST;
      q.rx_valid <= 1'b0;
      q.frame_start <= 1'b0;
      q.frame_end <= 1'b0;
      q.standby <= 1'b0;
      q.tx_hold <= sfpi_pkg::BYTE_RST;
    end else begin
      q <= d;
    end
  end

  assign rx_byte_o = q.rx_byte;
  assign rx_valid_o = q.rx_valid;
  assign frame_start_o = q.frame_start;
  assign frame_end_o = q.frame_end;
  assign selected_o = !q.cs_sync[1];
  assign hold_o = !q.hold_sync[1];
  assign hw_lock_o = !q.wp_sync[1];
  assign standby_o = q.standby;
  assign dual_read_o = q.dout_sync[1];
  assign dual_prog_o = q.din_sync[1];

endmodule // sfpi_top

// *** design/sfpi_pkg.sv ***
// Shared constants of the serial flash pin interface.
// Assumes a single-bit select, a serial clock from the host and two data lines.
package sfpi_pkg;

  // Frame layout around the dual commands.
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] DUMMY_BYTES = 3'h1;
  localparam logic [2:0] PROG_SWITCH = 3'h1 + ADDR_BYTES;
  localparam logic [2:0] READ_SWITCH = 3'h1 + ADDR_BYTES + DUMMY_BYTES;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;

  // Bits moved per clock edge and bits per byte.
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_DUAL = 4'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Opcode defaults of the two dual commands; the values are arbitrary.
  localparam logic [7:0] DUAL_READ_OP_DEF = 8'h5A;
  localparam logic [7:0] DUAL_PROG_OP_DEF = 8'hA5;

  // Reset values of the core side synchronisers and byte registers; pins idle high.
  localparam logic [1:0] PIN_SYNC_RST = 2'h3;
  localparam logic [1:0] LINK_SYNC_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// *** design/sfpi_rx_shift.sv ***
// Receive shifter on the rising edge of the serial clock.
// Assumes the host keeps select and hold stable around each rising edge.
`timescale 1ns/100ps
module sfpi_rx_shift #(
  parameter logic [7:0] DUAL_READ_OP = sfpi_pkg::DUAL_READ_OP_DEF,
  parameter logic [7:0] DUAL_PROG_OP = sfpi_pkg::DUAL_PROG_OP_DEF
) (
  // Clock and reset.
  input wire logic sck_i,
  input wire logic nrst_i,
  // Pins.
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic line_a_i,
  input wire logic line_b_i,
  // Frame state.
  output logic fresh_o,
  output logic byte_any_o,
  output logic boundary_o,
  output logic dual_in_o,
  output logic dual_out_o,
  output logic [7:0] data_o,
  output logic done_tog_o
);

  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] data;
    logic [7:0] opcode;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic dual_in;
    logic dual_out;
    logic done_tog;
  } sfpi_rx_s;

  sfpi_rx_s q;
  sfpi_rx_s d;
  logic fresh_q;

  // The select edge cannot be seen on this clock, so a flag set by the idle select marks the
  // next rising edge as the first one of a frame.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fresh_q <= 1'b1;
    end else if (hold_n_i) begin
      fresh_q <= 1'b0;
    end
  end

  always_comb begin
    sfpi_rx_s base;
    logic [3:0] sum;
    logic [2:0] nbytes;
    logic [7:0] op;
    base = q;
    sum = 4'h0;
    nbytes = 3'h0;
    op = 8'h00;
    if (fresh_q) begin
      base.bit_cnt = 3'h0;
      base.byte_cnt = 3'h0;
      base.dual_in = 1'b0;
      base.dual_out = 1'b0;
    end
    d = q;
    if (hold_n_i && !cs_n_i) begin
      d = base;
      if (base.dual_in) begin
        d.shift = {base.shift[5:0], line_a_i, line_b_i};
      end else begin
        d.shift = {base.shift[6:0], line_b_i};
      end
      if (base.dual_in || base.dual_out) begin
        sum = {1'b0, base.bit_cnt} + sfpi_pkg::STEP_DUAL;
      end else begin
        sum = {1'b0, base.bit_cnt} + sfpi_pkg::STEP_SINGLE;
      end
      d.bit_cnt = sum[2:0];
      if (sum == sfpi_pkg::BYTE_BITS) begin
        d.data = d.shift;
        d.done_tog = ~base.done_tog;
        if (base.byte_cnt == sfpi_pkg::BYTE_CNT_MAX) begin
          nbytes = base.byte_cnt;
        end else begin
          nbytes = base.byte_cnt + 3'h1;
        end
        d.byte_cnt = nbytes;
        op = (base.byte_cnt == 3'h0) ? d.shift : base.opcode;
        d.opcode = op;
        if (op == DUAL_PROG_OP && nbytes == sfpi_pkg::PROG_SWITCH) begin
          d.dual_in = 1'b1;
        end
        if (op == DUAL_READ_OP && nbytes == sfpi_pkg::READ_SWITCH) begin
          d.dual_out = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fresh_o = fresh_q;
  assign byte_any_o = !fresh_q && (q.byte_cnt != 3'h0);
  assign boundary_o = byte_any_o && (q.bit_cnt == 3'h0);
  assign dual_in_o = q.dual_in && !fresh_q;
  assign dual_out_o = q.dual_out && !fresh_q;
  assign data_o = q.data;
  assign done_tog_o = q.done_tog;

endmodule // sfpi_rx_shift

// *** design/sfpi_tx_shift.sv ***
// Transmit shifter on the falling edge of the serial clock.
// Assumes the reply byte is held stable by the core side across each byte boundary.
`timescale 1ns/100ps
module sfpi_tx_shift (
  // Clock and reset.
  input wire logic sck_i,
  input wire logic nrst_i,
  // Pins.
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  // Receive side state and the reply byte from the core.
  input wire logic boundary_i,
  input wire logic byte_any_i,
  input wire logic dual_out_i,
  input wire logic [7:0] tx_byte_i,
  // Line data and drive enable.
  output logic line_a_o,
  output logic line_b_o,
  output logic drive_o
);

  typedef struct packed {
    logic [7:0] shift;
    logic en;
  } sfpi_tx_s;

  sfpi_tx_s q;
  sfpi_tx_s d;

  always_comb begin
    d = q;
    if (hold_n_i && !cs_n_i) begin
      if (boundary_i) begin
        d.shift = tx_byte_i;
        d.en = 1'b1;
      end else begin
        if (!byte_any_i) begin
          d.en = 1'b0;
        end
        if (dual_out_i) begin
          d.shift = {q.shift[5:0], 2'b00};
        end else begin
          d.shift = {q.shift[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(negedge sck_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign line_a_o = q.shift[7];
  assign line_b_o = q.shift[6];
  assign drive_o = q.en;

endmodule // sfpi_tx_shift

// *** test/sfpi_monitor.sv ***
// Checker of the pin front end, bound to sfpi_top.
// Assumes the core clock samples the pins at least once per serial clock half period.
`timescale 1ns/100ps
module sfpi_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  input wire logic busy_i,
  input wire logic dual_data_line_a_o,
  input wire logic dual_data_line_a_oe_n_o,
  input wire logic dual_data_line_b_o,
  input wire logic dual_data_line_b_oe_n_o,
  input wire logic frame_start_o,
  input wire logic frame_end_o,
  input wire logic selected_o,
  input wire logic hw_lock_o,
  input wire logic standby_o,
  input wire logic dual_read_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_desel_float: assert property (cs_n_i |-> dual_data_line_a_oe_n_o && dual_data_line_b_oe_n_o)
    else $error("line driven while deselected");
  chk_hold_float: assert property (!hold_n_i |-> dual_data_line_a_oe_n_o && dual_data_line_b_oe_n_o)
    else $error("line driven during hold");
  chk_busy_standby: assert property (busy_i |=> !standby_o)
    else $error("standby while busy");
  chk_sel_standby: assert property (selected_o ##1 selected_o |-> !standby_o)
    else $error("standby while selected");
  chk_wp_lock: assert property ((!wp_n_i) [*5] |-> hw_lock_o)
    else $error("lock missing");
  chk_sel_level: assert property ((!cs_n_i) [*5] |-> selected_o)
    else $error("select lost");
  chk_frame_begin: assert property ($fell(cs_n_i) |-> ##[1:6] frame_start_o)
    else $error("frame start missing");
  chk_frame_close: assert property ($rose(cs_n_i) |-> ##[1:6] frame_end_o)
    else $error("frame end missing");
  // Select edges may clear the shifters, so only settled frames are checked.
  chk_line_fall: assert property (sck_i && !cs_n_i && $past(!cs_n_i) |->
    $stable({dual_data_line_a_o, dual_data_line_b_o}))
    else $error("line changed on rising edge");
  // The mode flag lags the line enable by the synchroniser, so the enable is judged two
  // cycles back.
  chk_b_drive: assert property ((!dual_read_o) [*3] |->
    $past(dual_data_line_b_oe_n_o, 2))
    else $error("line b driven outside dual read");
  cp_dual: cover property (dual_read_o && !dual_data_line_b_oe_n_o);
  cp_hold: cover property (!hold_n_i && !cs_n_i);
  cp_busy: cover property (busy_i && cs_n_i);
endmodule // sfpi_monitor
bind sfpi_top sfpi_monitor sfpi_monitor_i (.*);

// *** test/sfpi_host_model.sv ***
// Host model: frames transfers on the serial link and resolves both data lines.
// Assumes the device drives a line only while its enable is low.
`timescale 1ns/100ps
module sfpi_host_model (
  // Link outputs.
  output logic sck_o,
  output logic cs_n_o,
  output logic hold_n_o,
  output logic lvl_a_o,
  output logic lvl_b_o,
  // Device lines.
  input wire logic a_i,
  input wire logic a_oe_n_i,
  input wire logic b_i,
  input wire logic b_oe_n_i
);
  logic ha = 1'b0, hb = 1'b0, da = 1'b0, db = 1'b0, tgl = 1'b0;
  // Idle levels land after every process waits, so the select edge marks the first frame.
  initial begin
    sck_o <= 1'b0;
    cs_n_o <= 1'b1;
    hold_n_o <= 1'b1;
  end
  // A released line toggles, so a stale value can never pass for data.
  initial forever #3 tgl = ~tgl;
  assign lvl_a_o = !a_oe_n_i ? a_i : da ? ha : tgl;
  assign lvl_b_o = !b_oe_n_i ? b_i : db ? hb : tgl;
  task automatic start(input logic cpol);
    sck_o = cpol;
    #10 cs_n_o = 1'b0;
    #10;
  endtask
  task automatic stop(input logic cpol);
    #8 cs_n_o = 1'b1;
    sck_o = cpol;
    da = 1'b0;
    db = 1'b0;
    #30;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic [1:0] md, output logic [7:0] rx);
    for (int i = 7; i >= 0; i = i - (md != 2'h0 ? 2 : 1)) begin
      sck_o = 1'b0;
      db = md != 2'h2;
      da = md == 2'h1;
      ha = tx[i];
      hb = md == 2'h1 ? tx[i - 1] : tx[i];
      #7.5 sck_o = 1'b1;
      rx[i] = lvl_a_o;
      if (md != 2'h0) rx[i - 1] = lvl_b_o;
      #7.5;
    end
  endtask
  task automatic hold_on();
    sck_o = 1'b0;
    #5 hold_n_o = 1'b0;
    repeat (3) begin
      #5 sck_o = 1'b1;
      hb = ~hb;
      #5 sck_o = 1'b0;
    end
  endtask
  task automatic hold_off();
    #5 hold_n_o = 1'b1;
    #5;
  endtask
endmodule // sfpi_host_model

// *** test/tb.sv ***
// Testbench of the pin front end: host model on the link, core replies from a counter.
// The host model runs the serial clock inside frames, and once outside a frame in the deselect test.
`timescale 1ns/100ps
module tb;
  logic core_clk_i = 1'b0, nrst_i = 1'b1, wp_n_i = 1'b1, busy_i = 1'b0, tx_valid_i = 1'b0;
  logic sck_i, cs_n_i, hold_n_i, dual_data_line_a_i, dual_data_line_b_i, rx_valid_o;
  logic dual_data_line_a_o, dual_data_line_a_oe_n_o, dual_data_line_b_o, dual_data_line_b_oe_n_o;
  logic frame_start_o, frame_end_o, selected_o, hold_o, hw_lock_o, standby_o;
  logic dual_read_o, dual_prog_o;
  logic [7:0] tx_byte_i = 8'h00, rx_byte_o, cnt = 8'h00, txv [8];
  logic [7:0] rxq [$];
  int miscompares = 0, num_checks = 0;
  sfpi_top sfpi_top_i (.*);
  sfpi_host_model sfpi_host_model_i (.sck_o(sck_i), .cs_n_o(cs_n_i), .hold_n_o(hold_n_i),
    .lvl_a_o(dual_data_line_a_i), .lvl_b_o(dual_data_line_b_i), .a_i(dual_data_line_a_o),
    .a_oe_n_i(dual_data_line_a_oe_n_o), .b_i(dual_data_line_b_o),
    .b_oe_n_i(dual_data_line_b_oe_n_o));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  // The reply to byte N leaves after byte N+1, so a frame opens with 8'hBF preloaded.
  always @(posedge core_clk_i) begin
    tx_valid_i <= rx_valid_o;
    if (rx_valid_o) begin
      tx_byte_i <= 8'hC0 + cnt;
      cnt <= cnt + 8'h01;
      rxq.push_back(rx_byte_o);
    end
    if (frame_start_o) begin
      cnt <= 8'h00;
      tx_valid_i <= 1'b1;
      tx_byte_i <= 8'hBF;
    end
  end
  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic frame(input logic cpol, input int n, input int df, input logic prog, input int ha);
    logic [7:0] r;
    int lim;
    lim = (df < n && !prog) ? df : n;
    rxq.delete();
    sfpi_host_model_i.start(cpol);
    for (int k = 0; k < n; k++) begin
      if (k == ha) begin
        sfpi_host_model_i.hold_on();
        repeat (8) @(posedge core_clk_i);
        chk("hold", 8'h01, {7'h00, hold_o});
        chk("selected", 8'h01, {7'h00, selected_o});
        sfpi_host_model_i.hold_off();
      end
      if (k == df) begin
        // The mode flag crosses two synchroniser stages, so give it a few core cycles.
        repeat (3) @(posedge core_clk_i);
        chk("mode", 8'h01, {7'h00, prog ? dual_prog_o : dual_read_o});
      end
      sfpi_host_model_i.xfer(txv[k], k >= df ? (prog ? 2'h1 : 2'h2) : 2'h0, r);
      if (k > 0 && !(prog && k >= df)) chk("reply", 8'hC0 + 8'(k) - 8'h02, r);
    end
    sfpi_host_model_i.stop(cpol);
    for (int t = 0; t < 60 && rxq.size() < lim; t++) @(posedge core_clk_i);
    if (rxq.size() < lim) begin
      miscompares++;
      complete_run();
    end
    for (int k = 0; k < lim; k++) chk("rx", txv[k], rxq[k]);
  endtask
  task automatic sc_single();
    txv = '{8'h3C, 8'h96, 8'h0F, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00};
    frame(1'b0, 4, 9, 1'b0, 9);
    frame(1'b1, 4, 9, 1'b0, 9);
    frame(1'b0, 4, 9, 1'b0, 2);
  endtask
  task automatic sc_dual();
    txv = '{sfpi_pkg::DUAL_READ_OP_DEF, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00};
    frame(1'b0, 7, 5, 1'b0, 9);
    txv = '{sfpi_pkg::DUAL_PROG_OP_DEF, 8'h10, 8'h20, 8'h30, 8'h69, 8'hB2, 8'h00, 8'h00};
    frame(1'b0, 6, 4, 1'b1, 9);
  endtask
  task automatic sc_desel();
    logic [7:0] r;
    rxq.delete();
    sfpi_host_model_i.xfer(8'hE7, 2'h0, r);
    repeat (20) @(posedge core_clk_i);
    chk("desel_rx", 8'h00, 8'(rxq.size()));
    chk("standby", 8'h01, {7'h00, standby_o});
  endtask
  task automatic sc_busy();
    @(posedge core_clk_i);
    busy_i <= 1'b1;
    wp_n_i <= 1'b0;
    txv[0] = 8'h11;
    frame(1'b0, 2, 9, 1'b0, 1);
    repeat (6) @(posedge core_clk_i);
    chk("standby_busy", 8'h00, {7'h00, standby_o});
    chk("lock_on", 8'h01, {7'h00, hw_lock_o});
    busy_i <= 1'b0;
    wp_n_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk("standby_idle", 8'h01, {7'h00, standby_o});
    chk("lock_off", 8'h00, {7'h00, hw_lock_o});
  endtask
  initial begin
    // A real falling edge is needed to clear the link shifters asynchronously.
    nrst_i <= 1'b0;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sc_single();
    sc_desel();
    sc_dual();
    sc_busy();
    complete_run();
  end
endmodule // tb
